// File: logic/icr_regif.sv
// Purpose: software register interface of a two-wire bus controller, AXI4-Lite slave
// Assumes: bit-level engine on the same clock gives one-cycle event pulses
// Notes: registers in low byte lanes, upper bits read zero
// Operation
// - control bit 7 enables the controller
// - control bit 6 gates the interrupt request
// - master_select rise makes start, fall makes stop and slave mode
// - control bit 4 sets direction, 1 transmit, 0 receive
// - control bit 3 selects ack or no ack after received bytes
// - writing control bit 2 gives repeated start when master; reads 0
// - repeated start at improper time counts as arbitration loss
// - transfer_done_flag sets on byte done, cleared by data read in receive or data write in transmit
// - addressed_flag sets on address or general call match; control write clears
// - busy sets on start detect, clears on stop detect
// - arbitration_lost_flag set by hardware, cleared by writing 1
// - slave_direction_flag holds read/write bit of calling address
// - interrupt_pending_flag sets on done, match, arbitration loss; write 1 clears
// - received_ack_flag captures ack after each transmitted byte
// - data write in master transmit starts a byte, msb first
// - data read in master receive starts next byte reception
// - slave mode triggers like master mode after address match
// - data access triggers only when direction bit matches
// - data read returns last received byte only
// - first byte after master_select is the address byte
// - second control bit 7 enables general call recognition
`include "icr_params.svh"
module icr_regif
    import icr_pkg::*;
(
    input wire logic clock, // 40 MHz
    input wire logic reset, // sync, active high
    input wire icr_addr_t awaddr, // write address
    input wire logic awvalid, // write address valid
    output logic awready, // write address ready
    input wire logic [31:0] wdata, // write data
    input wire logic [3:0] wstrb, // byte strobes
    input wire logic wvalid, // write data valid
    output logic wready, // write data ready
    output icr_resp_t bresp, // write response
    output logic bvalid, // write response valid
    input wire logic bready, // write response ready
    input wire icr_addr_t araddr, // read address
    input wire logic arvalid, // read address valid
    output logic arready, // read address ready
    output logic [31:0] rdata, // read data
    output icr_resp_t rresp, // read response
    output logic rvalid, // read data valid
    input wire logic rready, // read data ready
    input wire logic engStartDetect, // start seen on bus
    input wire logic engStopDetect, // stop seen on bus
    input wire logic engByteDone, // byte incl. ack finished
    input wire logic engArbLost, // arbitration lost
    input wire logic engAddrMatch, // calling address matched own
    input wire logic engGenCall, // general call received
    input wire logic engRwBit, // r/w bit of calling address
    input wire logic engAckBit, // sampled ack, 0 = ack
    input wire icr_byte_t engRxData, // received byte
    output logic engEnable, // controller enabled
    output logic engMaster, // master mode
    output logic engTransmit, // direction, 1 transmit
    output logic engNoAck, // send no ack
    output logic engGenCallEn, // general call recognition
    output logic [6:0] engSlaveAddr, // own slave address
    output logic engStartReq, // pulse: make start
    output logic engStopReq, // pulse: make stop
    output logic engRepStartReq, // pulse: repeated start
    output logic engTxReq, // pulse: send engTxData
    output logic engRxReq, // pulse: receive a byte
    output logic engAddrByte, // level: byte sent is address
    output icr_byte_t engTxData, // byte to send
    output logic irq // interrupt request
);
    logic awHeld_r;
    logic wHeld_r;
    icr_addr_t awAddr_r;
    icr_byte_t wData_r;
    logic wLane_r;
    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    icr_resp_t bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    icr_resp_t rresp_r;
    logic [4:0] ctrl_r;
    logic gcEn_r;
    logic [6:0] saddr_r;
    logic tcf_r;
    logic addressed_flag_r;
    logic busy_r;
    logic arbitration_lost_flag_r;
    logic srw_r;
    logic iif_r;
    logic received_ack_flag_r;
    logic slaveAct_r;
    logic xferBusy_r;
    logic addrPhase_r;
    icr_byte_t rxData_r;
    icr_byte_t txData_r;
    logic startReq_r;
    logic stopReq_r;
    logic repReq_r;
    logic txReq_r;
    logic rxReq_r;
    logic irq_r;

    // write and read channel handshakes
    wire awTake = awvalid & awready_r;
    wire wTake = wvalid & wready_r;
    wire doWrite = awHeld_r & wHeld_r & ~bvalid_r;
    wire awHeldNxt = (awHeld_r | awTake) & ~doWrite;
    wire wHeldNxt = (wHeld_r | wTake) & ~doWrite;
    wire bvalidNxt = doWrite | (bvalid_r & ~bready);
    wire arTake = arvalid & arready_r;
    wire rvalidNxt = arTake | (rvalid_r & ~rready);

    // address decode
    wire wIsCtrl = (awAddr_r == `ICR_OFS_CTRL);
    wire wIsStat = (awAddr_r == `ICR_OFS_STAT);
    wire wIsData = (awAddr_r == `ICR_OFS_DATA);
    wire wIsCtrl2 = (awAddr_r == `ICR_OFS_CTRL2);
    wire wIsSaddr = (awAddr_r == `ICR_OFS_SADDR);
    wire wMapped = wIsCtrl | wIsStat | wIsData | wIsCtrl2 | wIsSaddr;
    wire rIsCtrl = (araddr == `ICR_OFS_CTRL);
    wire rIsStat = (araddr == `ICR_OFS_STAT);
    wire rIsData = (araddr == `ICR_OFS_DATA);
    wire rIsCtrl2 = (araddr == `ICR_OFS_CTRL2);
    wire rIsSaddr = (araddr == `ICR_OFS_SADDR);
    wire rMapped = rIsCtrl | rIsStat | rIsData | rIsCtrl2 | rIsSaddr;
    // a write without the low lane stores nothing
    wire wEff = doWrite & wLane_r;
    wire wrCtrl = wEff & wIsCtrl;
    wire wrStat = wEff & wIsStat;
    wire wrData = wEff & wIsData;
    wire rdData = arTake & rIsData;

    // control fields
    wire en = ctrl_r[`ICR_B_EN - 3];
    wire ie = ctrl_r[`ICR_B_IE - 3];
    wire master_select = ctrl_r[`ICR_B_MST - 3];
    wire txSel = ctrl_r[`ICR_B_TX - 3];
    wire newMst = wData_r[`ICR_B_MST];
    // enable and master may arrive in one write; the new enable decides
    wire mstRise = wrCtrl & newMst & ~master_select & wData_r[`ICR_B_EN] & ~engArbLost;
    wire mstFall = wrCtrl & ~newMst & master_select & ~engArbLost;
    // repeat start only between bytes while master, else lost arbitration
    wire rstaWr = wrCtrl & wData_r[`ICR_B_REPEAT_START_TRIGGER];
    wire rstaOk = master_select & ~xferBusy_r & busy_r & en;
    wire rstaBad = rstaWr & ~rstaOk;
    wire arbSet = engArbLost | rstaBad;
    wire active = en & (master_select | slaveAct_r);
    wire txGo = wrData & active & txSel & ~xferBusy_r;
    wire rxGo = rdData & active & ~txSel & ~xferBusy_r;
    wire addrHit = engAddrMatch | (engGenCall & gcEn_r);
    wire [7:0] statByte = {tcf_r, addressed_flag_r, busy_r, arbitration_lost_flag_r, 1'b0, srw_r, iif_r, received_ack_flag_r};
    wire [7:0] ctrlByte = {ctrl_r, 3'h0};
    wire [7:0] rdByte = rIsCtrl ? ctrlByte
        : rIsStat ? statByte
        : rIsData ? rxData_r
        : rIsCtrl2 ? {gcEn_r, 7'h00}
        : rIsSaddr ? {saddr_r, 1'b0}
        : 8'h00;

    // bus slave
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
        end
        else
        begin
            awHeld_r <= awHeldNxt;
            wHeld_r <= wHeldNxt;
            awready_r <= ~awHeldNxt & ~bvalidNxt;
            wready_r <= ~wHeldNxt & ~bvalidNxt;
            bvalid_r <= bvalidNxt;
            arready_r <= ~rvalidNxt;
            rvalid_r <= rvalidNxt;
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            awAddr_r <= 8'h00;
            wData_r <= 8'h00;
            wLane_r <= 1'b0;
            bresp_r <= `ICR_RESP_OKAY;
            rdata_r <= 32'h00000000;
            rresp_r <= `ICR_RESP_OKAY;
        end
        else
        begin
            if (awTake)
                awAddr_r <= awaddr;
            if (wTake)
            begin
                wData_r <= wdata[7:0];
                wLane_r <= wstrb[0];
            end
            if (doWrite)
                bresp_r <= wMapped ? `ICR_RESP_OKAY : `ICR_RESP_SLVERR;
            if (arTake)
            begin
                rdata_r <= {24'h000000, rdByte};
                rresp_r <= rMapped ? `ICR_RESP_OKAY : `ICR_RESP_SLVERR;
            end
        end
    end

    // control, address and data registers
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            ctrl_r <= `ICR_RST_CTRL;
            gcEn_r <= 1'b0;
            saddr_r <= `ICR_RST_SADDR;
            txData_r <= 8'h00;
            rxData_r <= 8'h00;
        end
        else
        begin
            if (wrCtrl)
                ctrl_r <= wData_r[7:3];
            // lost arbitration drops to slave without a stop
            if (engArbLost)
                ctrl_r[`ICR_B_MST - 3] <= 1'b0;
            if (wEff & wIsCtrl2)
                gcEn_r <= wData_r[`ICR_B_GCEN];
            if (wEff & wIsSaddr)
                saddr_r <= wData_r[7:1];
            if (txGo)
                txData_r <= wData_r;
            if (engByteDone & ~txSel)
                rxData_r <= engRxData;
        end
    end

    // status flags: hardware set wins over software clear
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            tcf_r <= `ICR_RST_TCF;
            addressed_flag_r <= 1'b0;
            busy_r <= 1'b0;
            arbitration_lost_flag_r <= 1'b0;
            srw_r <= 1'b0;
            iif_r <= 1'b0;
            received_ack_flag_r <= `ICR_RST_RECEIVED_ACK_FLAG;
            slaveAct_r <= 1'b0;
        end
        else
        begin
            if (engByteDone)
                tcf_r <= 1'b1;
            else if ((rdData & ~txSel) | (wrData & txSel))
                tcf_r <= 1'b0;
            if (addrHit)
                addressed_flag_r <= 1'b1;
            else if (wrCtrl)
                addressed_flag_r <= 1'b0;
            if (engStartDetect)
                busy_r <= 1'b1;
            else if (engStopDetect)
                busy_r <= 1'b0;
            if (arbSet)
                arbitration_lost_flag_r <= 1'b1;
            else if (wrStat & wData_r[`ICR_B_ARBITRATION_LOST_FLAG])
                arbitration_lost_flag_r <= 1'b0;
            if (addrHit)
                srw_r <= engRwBit;
            if (engByteDone | addrHit | arbSet)
                iif_r <= 1'b1;
            else if (wrStat & wData_r[`ICR_B_IIF])
                iif_r <= 1'b0;
            if (engByteDone & txSel)
                received_ack_flag_r <= engAckBit;
            if (addrHit)
                slaveAct_r <= 1'b1;
            else if (engStopDetect | engStartDetect | ~en)
                slaveAct_r <= 1'b0;
        end
    end

    // engine requests, one-cycle pulses
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            startReq_r <= 1'b0;
            stopReq_r <= 1'b0;
            repReq_r <= 1'b0;
            txReq_r <= 1'b0;
            rxReq_r <= 1'b0;
            xferBusy_r <= 1'b0;
            addrPhase_r <= 1'b0;
            irq_r <= 1'b0;
        end
        else
        begin
            startReq_r <= mstRise;
            stopReq_r <= mstFall;
            repReq_r <= rstaWr & rstaOk;
            txReq_r <= txGo;
            rxReq_r <= rxGo;
            // one byte at a time; the engine closes it with engByteDone or engArbLost
            if (txGo | rxGo)
                xferBusy_r <= 1'b1;
            else if (engByteDone | engArbLost)
                xferBusy_r <= 1'b0;
            if (mstRise | (rstaWr & rstaOk))
                addrPhase_r <= 1'b1;
            else if (engByteDone | engArbLost | mstFall)
                addrPhase_r <= 1'b0;
            irq_r <= iif_r & ie;
        end
    end

    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;
    assign engEnable = ctrl_r[`ICR_B_EN - 3];
    assign engMaster = ctrl_r[`ICR_B_MST - 3];
    assign engTransmit = ctrl_r[`ICR_B_TX - 3];
    assign engNoAck = ctrl_r[`ICR_B_ACK_DRIVE_CONTROL - 3];
    assign engGenCallEn = gcEn_r;
    assign engSlaveAddr = saddr_r;
    assign engStartReq = startReq_r;
    assign engStopReq = stopReq_r;
    assign engRepStartReq = repReq_r;
    assign engTxReq = txReq_r;
    assign engRxReq = rxReq_r;
    assign engAddrByte = addrPhase_r;
    assign engTxData = txData_r;
    assign irq = irq_r;

    // checks
    sequence sMstUp;
        mstRise;
    endsequence
    sequence sStartOut;
        engStartReq ##0 engMaster;
    endsequence

    a_irq_gating: assert property (@(posedge clock) disable iff (reset)
        irq == $past(iif_r & ie))
        else $error("irq not pending and enable");
    a_start_on_mst: assert property (@(posedge clock) disable iff (reset)
        sMstUp |=> sStartOut)
        else $error("no start after master select rise");
    a_stop_on_clear: assert property (@(posedge clock) disable iff (reset)
        mstFall |=> engStopReq && !engMaster)
        else $error("no stop after master select fall");
    a_repeat_start_trigger_zero: assert property (@(posedge clock) disable iff (reset)
        arTake && rIsCtrl |=> rvalid && !rdata[`ICR_B_REPEAT_START_TRIGGER])
        else $error("repeat start bit read back set");
    a_bad_repeat: assert property (@(posedge clock) disable iff (reset)
        rstaWr && !master_select |=> arbitration_lost_flag_r && iif_r && !engRepStartReq)
        else $error("improper repeat start not lost");
    a_tcf_set: assert property (@(posedge clock) disable iff (reset)
        engByteDone |=> tcf_r)
        else $error("done flag not set");
    a_addressed_flag_clear: assert property (@(posedge clock) disable iff (reset)
        wrCtrl && !addrHit |=> !addressed_flag_r)
        else $error("addressed flag survived control write");
    a_busy_track: assert property (@(posedge clock) disable iff (reset)
        engStopDetect && !engStartDetect |=> !busy_r ##1 busy_r == $past(engStartDetect | busy_r))
        else $error("busy flag wrong");
    a_arbitration_lost_flag_hold: assert property (@(posedge clock) disable iff (reset)
        arbitration_lost_flag_r && !(wrStat && wData_r[`ICR_B_ARBITRATION_LOST_FLAG]) |=> arbitration_lost_flag_r)
        else $error("lost flag cleared without write");
    a_srw_capture: assert property (@(posedge clock) disable iff (reset)
        addrHit |=> srw_r == $past(engRwBit) && addressed_flag_r)
        else $error("slave direction not captured");
    a_received_ack_flag_capture: assert property (@(posedge clock) disable iff (reset)
        engByteDone && txSel |=> received_ack_flag_r == $past(engAckBit))
        else $error("ack not captured");
    a_tx_trigger: assert property (@(posedge clock) disable iff (reset)
        txGo |=> engTxReq && engTxData == $past(wData_r) ##1 !engTxReq)
        else $error("data write did not start one byte");
    a_rx_direction: assert property (@(posedge clock) disable iff (reset)
        rdData && txSel |=> !engRxReq)
        else $error("read in transmit started reception");
endmodule

// File: logic/icr_params.svh
// Purpose: register map, field positions and reset values of the I2C register interface
// Assumes: byte offsets on a 32-bit AXI4-Lite bus, 8-bit registers in the low lanes
// Notes: definitions only
`ifndef ICR_PARAMS_SVH
`define ICR_PARAMS_SVH
`define ICR_OFS_CTRL 8'h00
`define ICR_OFS_STAT 8'h04
`define ICR_OFS_DATA 8'h08
`define ICR_OFS_CTRL2 8'h0c
`define ICR_OFS_SADDR 8'h10
`define ICR_B_EN 7
`define ICR_B_IE 6
`define ICR_B_MST 5
`define ICR_B_TX 4
`define ICR_B_ACK_DRIVE_CONTROL 3
`define ICR_B_REPEAT_START_TRIGGER 2
`define ICR_B_TCF 7
`define ICR_B_ADDRESSED_FLAG 6
`define ICR_B_BUSY 5
`define ICR_B_ARBITRATION_LOST_FLAG 4
`define ICR_B_SRW 2
`define ICR_B_IIF 1
`define ICR_B_RECEIVED_ACK_FLAG 0
`define ICR_B_GCEN 7
`define ICR_RST_CTRL 5'h00
`define ICR_RST_TCF 1'b1
`define ICR_RST_RECEIVED_ACK_FLAG 1'b1
`define ICR_RST_SADDR 7'h00
`define ICR_RESP_OKAY 2'h0
`define ICR_RESP_SLVERR 2'h2
`endif

// File: logic/icr_pkg.sv
// Purpose: shared types of the I2C register interface
// Assumes: constants live in icr_params.svh
// Notes: none
package icr_pkg;
    typedef logic [7:0] icr_byte_t;
    typedef logic [1:0] icr_resp_t;
    typedef logic [7:0] icr_addr_t;
endpackage

// File: bench/icr_engine_model.sv
// Purpose: behavioural bit engine answering the register block's requests
// Assumes: one clock, requests are one-cycle pulses
// Notes: byte takes BYTE_CYCLES; undriven data shows the inverse value
module icr_engine_model
    import icr_pkg::*;
#(
    parameter int BYTE_CYCLES = 8,
    parameter icr_byte_t RX_BYTE = 8'h5a
)
(
    input wire logic clock, // bench clock
    input wire logic reset, // sync, active high
    input wire logic engStartReq, // make start
    input wire logic engStopReq, // make stop
    input wire logic engRepStartReq, // make repeated start
    input wire logic engTxReq, // send a byte
    input wire logic engRxReq, // receive a byte
    input wire logic cmdArb, // bench: lose arbitration
    input wire logic cmdMatch, // bench: own address called
    input wire logic cmdRw, // bench: r/w bit of the call
    input wire logic cmdGen, // bench: general call seen
    input wire logic ackVal, // bench: ack level of the far side
    output logic engStartDetect, // start seen
    output logic engStopDetect, // stop seen
    output logic engByteDone, // byte finished
    output logic engArbLost, // arbitration lost
    output logic engAddrMatch, // address matched
    output logic engGenCall, // general call seen
    output logic engRwBit, // r/w of the call
    output logic engAckBit, // sampled ack
    output icr_byte_t engRxData // received byte
);
    timeunit 1ns;
    timeprecision 100ps;
    int cnt_r;
    always_ff @(posedge clock)
    begin
        engStartDetect <= !reset && (engStartReq || engRepStartReq);
        engStopDetect <= !reset && engStopReq;
        engArbLost <= !reset && cmdArb;
        engAddrMatch <= !reset && cmdMatch;
        engGenCall <= !reset && cmdGen;
        if (reset || cmdArb)
            cnt_r <= 0;
        else if (engTxReq || engRxReq)
            cnt_r <= BYTE_CYCLES;
        else if (cnt_r != 0)
            cnt_r <= cnt_r - 1;
    end
    assign engByteDone = (cnt_r == 1);
    // outside their strobe these carry the inverse, never a stale valid value
    assign engAckBit = engByteDone ? ackVal : !ackVal;
    assign engRxData = engByteDone ? RX_BYTE : ~RX_BYTE;
    assign engRwBit = engAddrMatch ? cmdRw : !cmdRw;
endmodule

// File: bench/tb_icr_regif.sv
// Purpose: register-level test of the bus controller register block
// Assumes: engine model answers every byte request after 8 cycles
// Notes: registers reached only through AXI4-Lite tasks
`include "icr_params.svh"
module tb_icr_regif
    import icr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock, reset, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
    logic rvalid, rready, sd, pd, bd, al, am, gc, rw, ak, cmdArb, cmdMatch, cmdRw, ackVal;
    logic engEnable, engMaster, engTransmit, engNoAck, engGenCallEn, irq, cmdGen;
    logic engStartReq, engStopReq, engRepStartReq, engTxReq, engRxReq, engAddrByte;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [6:0] engSlaveAddr;
    icr_addr_t awaddr, araddr;
    icr_resp_t bresp, rresp;
    icr_byte_t rxd, engTxData;
    int nMismatch = 0, checks = 0, nTx = 0, nRx = 0, nStart = 0, nStop = 0, nRep = 0;

    icr_regif u_dut (.clock(clock), .reset(reset), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .engStartDetect(sd), .engStopDetect(pd), .engByteDone(bd), .engArbLost(al),
        .engAddrMatch(am), .engGenCall(gc), .engRwBit(rw), .engAckBit(ak), .engRxData(rxd),
        .engEnable(engEnable), .engMaster(engMaster), .engTransmit(engTransmit),
        .engNoAck(engNoAck), .engGenCallEn(engGenCallEn), .engSlaveAddr(engSlaveAddr),
        .engStartReq(engStartReq), .engStopReq(engStopReq), .engRepStartReq(engRepStartReq),
        .engTxReq(engTxReq), .engRxReq(engRxReq), .engAddrByte(engAddrByte),
        .engTxData(engTxData), .irq(irq));

    icr_engine_model u_eng (.clock(clock), .reset(reset), .engStartReq(engStartReq),
        .engStopReq(engStopReq), .engRepStartReq(engRepStartReq), .engTxReq(engTxReq),
        .engRxReq(engRxReq), .cmdArb(cmdArb), .cmdMatch(cmdMatch), .cmdRw(cmdRw),
        .ackVal(ackVal), .engStartDetect(sd), .engStopDetect(pd), .engByteDone(bd),
        .engArbLost(al), .engAddrMatch(am), .engGenCall(gc), .engRwBit(rw),
        .engAckBit(ak), .engRxData(rxd), .cmdGen(cmdGen));

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = !clock;
    end

    // request pulses are one cycle wide, so counting them shows each trigger
    always @(posedge clock)
    begin
        nTx += (engTxReq === 1'b1);
        nRx += (engRxReq === 1'b1);
        nStart += (engStartReq === 1'b1);
        nStop += (engStopReq === 1'b1);
        nRep += (engRepStartReq === 1'b1);
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            nMismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        if (nMismatch == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic wr(input icr_addr_t a, input icr_byte_t d, input icr_resp_t er = 2'h0);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        awaddr <= a;
        wdata <= {24'h000000, d};
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (aw || w)
        begin
            @(posedge clock);
            aw = aw && (awready !== 1'b1);
            w = w && (wready !== 1'b1);
            awvalid <= aw;
            wvalid <= w;
        end
        while (bvalid !== 1'b1) @(posedge clock);
        check("bresp", bresp, er);
        bready <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rdc(input string what, input icr_addr_t a, input icr_byte_t exp,
                       input icr_resp_t er = 2'h0);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        @(posedge clock);
        while (arready !== 1'b1) @(posedge clock);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge clock);
        check(what, rdata, {24'h000000, exp});
        check("rresp", rresp, er);
        rready <= 1'b0;
        @(posedge clock);
    endtask

    initial
    begin
        // budget: the sequence needs well under 2000 cycles
        #(25 * 5000);
        nMismatch++;
        give_verdict();
    end

    initial
    begin
        reset = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready, cmdArb, cmdMatch, cmdRw, ackVal} = '0;
        cmdGen = 1'b0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = '0;
        tick(10);
        reset <= 1'b0;
        rdc("control", `ICR_OFS_CTRL, 8'h00);
        rdc("status", `ICR_OFS_STAT, 8'h81);
        rdc("unmapped", 8'h14, 8'h00, `ICR_RESP_SLVERR);
        wr(8'h18, 8'h55, `ICR_RESP_SLVERR);
        wr(`ICR_OFS_CTRL, 8'hb0);
        check("starts", nStart, 1);
        check("enable", engEnable, 1'b1);
        check("transmit", engTransmit, 1'b1);
        tick(4);
        rdc("status", `ICR_OFS_STAT, 8'ha1);
        wr(`ICR_OFS_DATA, 8'ha4);
        check("tx count", nTx, 1);
        check("tx byte", engTxData, 8'ha4);
        check("address byte", engAddrByte, 1'b1);
        rdc("status", `ICR_OFS_STAT, 8'h21);
        tick(20);
        rdc("status", `ICR_OFS_STAT, 8'ha2);
        check("irq masked", irq, 1'b0);
        wr(`ICR_OFS_CTRL, 8'hf0);
        tick(2);
        check("irq", irq, 1'b1);
        wr(`ICR_OFS_STAT, 8'h02);
        tick(2);
        check("irq cleared", irq, 1'b0);
        ackVal <= 1'b1;
        wr(`ICR_OFS_DATA, 8'h3c);
        check("address byte", engAddrByte, 1'b0);
        tick(20);
        rdc("status", `ICR_OFS_STAT, 8'ha3);
        wr(`ICR_OFS_CTRL, 8'hf4);
        check("rep starts", nRep, 1);
        rdc("control", `ICR_OFS_CTRL, 8'hf0);
        wr(`ICR_OFS_CTRL, 8'he8);
        check("no ack", engNoAck, 1'b1);
        check("receive", engTransmit, 1'b0);
        rdc("data", `ICR_OFS_DATA, 8'h00);
        check("rx count", nRx, 1);
        tick(20);
        wr(`ICR_OFS_STAT, 8'h02);
        rdc("status", `ICR_OFS_STAT, 8'ha1);
        wr(`ICR_OFS_CTRL, 8'hf0);
        rdc("data", `ICR_OFS_DATA, 8'h5a);
        check("rx count", nRx, 1);
        wr(`ICR_OFS_CTRL, 8'hd0);
        check("stops", nStop, 1);
        tick(4);
        rdc("status", `ICR_OFS_STAT, 8'h81);
        wr(`ICR_OFS_CTRL, 8'hd4);
        rdc("status", `ICR_OFS_STAT, 8'h93);
        wr(`ICR_OFS_STAT, 8'h10);
        rdc("status", `ICR_OFS_STAT, 8'h83);
        wr(`ICR_OFS_STAT, 8'h02);
        wr(`ICR_OFS_CTRL, 8'hf0);
        tick(4);
        cmdArb <= 1'b1;
        @(posedge clock);
        cmdArb <= 1'b0;
        tick(3);
        check("master", engMaster, 1'b0);
        rdc("status", `ICR_OFS_STAT, 8'hb3);
        check("stops", nStop, 1);
        wr(`ICR_OFS_STAT, 8'h12);
        wr(`ICR_OFS_SADDR, 8'ha4);
        check("slave addr", engSlaveAddr, 7'h52);
        cmdRw <= 1'b1;
        cmdMatch <= 1'b1;
        @(posedge clock);
        cmdMatch <= 1'b0;
        tick(3);
        rdc("status", `ICR_OFS_STAT, 8'he7);
        wr(`ICR_OFS_CTRL, 8'h90);
        wr(`ICR_OFS_DATA, 8'h77);
        check("tx count", nTx, 3);
        rdc("status", `ICR_OFS_STAT, 8'h27);
        wr(`ICR_OFS_CTRL2, 8'h80);
        check("general call", engGenCallEn, 1'b1);
        tick(8);
        cmdGen <= 1'b1;
        @(posedge clock);
        cmdGen <= 1'b0;
        tick(3);
        rdc("status", `ICR_OFS_STAT, 8'he3);
        wr(`ICR_OFS_CTRL, 8'h00);
        check("enable", engEnable, 1'b0);
        give_verdict();
    end
endmodule
